// >>> hdl/urm_channel.sv
`timescale 1ns/100ps
// ******************************************************
// Serial channel register map and interrupt logic
// ******************************************************
module urm_channel import urm_pkg::*; #(
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic        i_mclk,          // Device clock, 40 MHz
	input  wire logic        i_sys_rst,       // Async reset, high
	input  wire logic        i_cs,            // Channel select
	input  wire logic        i_rd,            // Read strobe, one cycle
	input  wire logic        i_wr,            // Write strobe, one cycle
	input  wire logic [2:0]  i_addr,          // Register offset
	input  wire logic [7:0]  i_wdata,         // Write data
	input  wire logic        i_rx_valid,      // Receive shifter delivers a byte
	input  wire logic [7:0]  i_rx_data,       // Received byte
	input  wire logic        i_rx_parity_err, // Byte had a parity error
	input  wire logic        i_rx_frame_err,  // Byte had a framing error
	input  wire logic        i_rx_break,      // Byte was a break
	input  wire logic        i_tx_take,       // Transmit shifter takes o_tx_data
	input  wire logic        i_tx_busy,       // Transmit shifter holds data
	input  wire logic [3:0]  i_modem_delta,   // Modem line change pulses
	input  wire logic [3:0]  i_modem_lines,   // Modem line levels
	output logic      [7:0]  o_rdata,         // Read data
	output logic             o_irq,           // Channel interrupt, high
	output logic      [15:0] o_divisor,       // Baud divisor
	output logic      [7:0]  o_frame_format,  // Frame format control
	output logic      [4:0]  o_pin_control,   // Handshake pin control
	output logic             o_fifo_en,       // Queues enabled
	output logic             o_dma_mode,      // DMA mode selected
	output logic      [7:0]  o_tx_data,       // Byte for transmit shifter
	output logic             o_tx_valid       // o_tx_data is loaded
);
	localparam int CW = $clog2(DEPTH) + 1;

	// ******************************************************
	// Helpers
	// ******************************************************
	// Trigger level for a select code
	function automatic logic [CW-1:0] trig_level(input logic [1:0] sel);
		logic [4:0] lvl;
		lvl = TRIG_L0;
		case (sel)
			2'h1:    lvl = TRIG_L1;
			2'h2:    lvl = TRIG_L2;
			2'h3:    lvl = TRIG_L3;
			default: lvl = TRIG_L0;
		endcase
		return CW'(lvl);
	endfunction : trig_level

	// ******************************************************
	// Software state
	// ******************************************************
	logic [3:0]    interrupt_enable;                           // Interrupt enables
	logic [7:0]    frame_format_control;                           // Frame format control
	logic [7:0]    dll;                           // Divisor low
	logic [7:0]    baud_divisor_high;                           // Divisor high
	logic [4:0]    handshake_pin_control;                           // Pin control, low five bits
	logic [7:0]    scratch_byte;                           // Scratch
	logic          fifo_en;                       // Queue mode
	logic          dma_mode;                      // DMA mode
	logic [1:0]    trig_sel;                      // Receive trigger select
	logic          overrun;                       // Sticky overrun
	logic          head_ack;                      // Head errors seen by line read
	logic [CW-1:0] err_cnt;                       // Errored entries queued
	logic          tx_pend;                       // Transmit ready pending
	logic          tx_empty_q;                    // Queue empty last cycle
	logic [3:0]    mdelta;                        // Sticky modem changes

	// ******************************************************
	// Access decode
	// ******************************************************
	wire       rd   = i_cs & i_rd;                // Read request
	wire       wr   = i_cs & i_wr;                // Write request
	wire       dlab = frame_format_control[FRM_DIV_ACCESS];        // Divisor overlay on
	wire       a_dat = (i_addr == OFS_DATA);
	wire       a_ien = (i_addr == OFS_IEN);
	wire       wr_thr = wr & a_dat & ~dlab;
	wire       wr_dll = wr & a_dat & dlab;
	wire       wr_ier = wr & a_ien & ~dlab;
	wire       wr_dlm = wr & a_ien & dlab;
	wire       wr_fcr = wr & (i_addr == OFS_ISRC);
	wire       wr_lcr = wr & (i_addr == OFS_FRAME);
	wire       wr_mcr = wr & (i_addr == OFS_PINS);
	wire       wr_spr = wr & (i_addr == OFS_SCR);
	wire       rd_rhr = rd & a_dat & ~dlab;
	wire       rd_isr = rd & (i_addr == OFS_ISRC);
	wire       rd_lsr = rd & (i_addr == OFS_LINE);
	wire       rd_msr = rd & (i_addr == OFS_MODEM);

	// Queue flush on explicit request or on mode change, since old data is meaningless
	wire       fen_chg  = wr_fcr & (i_wdata[QC_FIFO_EN] != fifo_en);
	wire       rx_flush = fen_chg | (wr_fcr & i_wdata[QC_FIFO_EN] & i_wdata[QC_RX_FLUSH]);
	wire       tx_flush = fen_chg | (wr_fcr & i_wdata[QC_FIFO_EN] & i_wdata[QC_TX_FLUSH]);

	// ******************************************************
	// Receive queue
	// ******************************************************
	logic [RX_WIDTH-1:0] rx_head;                 // Head entry with tags
	logic [CW-1:0]       rx_count;                // Receive level
	logic                rx_empty;                // Receive queue empty
	logic                rx_full;                 // Receive queue full

	// Without queues the holding position is a single slot
	wire       rx_cap_full = fifo_en ? rx_full : ~rx_empty;
	wire [2:0] rx_tags     = {i_rx_break, i_rx_frame_err, i_rx_parity_err};
	wire       rx_push     = i_rx_valid & ~rx_cap_full;
	wire       rx_lost     = i_rx_valid & rx_cap_full;
	wire       rx_pop      = rd_rhr & ~rx_empty;
	wire       head_bad    = ~rx_empty & (|rx_head[10:8]);

	urm_fifo #(
		.WIDTH (RX_WIDTH),
		.DEPTH (DEPTH)
	) u_rx_fifo (
		.i_mclk    (i_mclk),
		.i_sys_rst (i_sys_rst),
		.i_flush   (rx_flush),
		.i_push    (rx_push),
		.i_din     ({rx_tags, i_rx_data}),
		.i_pop     (rx_pop),
		.o_head    (rx_head),
		.o_count   (rx_count),
		.o_empty   (rx_empty),
		.o_full    (rx_full)
	);

	// ******************************************************
	// Transmit queue and shifter hand-off stage
	// ******************************************************
	logic [7:0]    tx_head;                       // Next byte to send
	logic          tx_empty;                      // Transmit queue empty
	logic          tx_full;                       // Transmit queue full

	wire       tx_cap_full = fifo_en ? tx_full : ~tx_empty;
	wire       tx_push     = wr_thr & ~tx_cap_full;   // Write to a full queue is lost
	wire       tx_load     = ~tx_empty & (~o_tx_valid | i_tx_take);

	urm_fifo #(
		.WIDTH (8),
		.DEPTH (DEPTH)
	) u_tx_fifo (
		.i_mclk    (i_mclk),
		.i_sys_rst (i_sys_rst),
		.i_flush   (tx_flush),
		.i_push    (tx_push),
		.i_din     (i_wdata),
		.i_pop     (tx_load),
		.o_head    (tx_head),
		.o_count   (),
		.o_empty   (tx_empty),
		.o_full    (tx_full)
	);

	// ******************************************************
	// Line flags
	// ******************************************************
	wire [2:0] head_err = (~rx_empty & ~head_ack) ? rx_head[10:8] : 3'h0;
	wire       temt     = tx_empty & ~o_tx_valid & ~i_tx_busy;
	wire [7:0] serial_line_flags      = {(err_cnt != '0),
	                       temt,
	                       tx_empty,
	                       head_err,
	                       overrun,
	                       ~rx_empty};

	// ******************************************************
	// Interrupt sources
	// ******************************************************
	wire       src_line  = interrupt_enable[2] & (overrun | (|head_err));
	wire       src_rxd   = interrupt_enable[0] & (fifo_en ? (rx_count >= trig_level(trig_sel))
	                                         : ~rx_empty);
	wire       src_txr   = interrupt_enable[IEN_TXR] & tx_pend;
	wire       src_modem = interrupt_enable[3] & (|mdelta);
	logic [3:0] isr_code;                                                    // Prioritised code

	// Each enabled source reports through the status code
	urm_irq_prio u_prio (
		.i_line  (src_line),
		.i_rxd   (src_rxd),
		.i_txr   (src_txr),
		.i_modem (src_modem),
		.o_code  (isr_code)
	);

	wire [7:0] interrupt_source = {fifo_en, fifo_en, 2'h0, isr_code};

	// Transmit ready events; set takes priority over the clears
	wire       tx_went_empty = tx_empty & ~tx_empty_q;
	wire       tx_arm_empty  = wr_ier & i_wdata[IEN_TXR] & ~interrupt_enable[IEN_TXR] & tx_empty;
	wire       tx_set        = tx_went_empty | tx_arm_empty;
	wire       tx_clr        = rd_isr | wr_thr;

	// ******************************************************
	// Read data selection
	// ******************************************************
	wire [7:0] rd_mux = (i_addr == OFS_DATA)  ? (dlab ? dll : rx_head[7:0]) :
	                    (i_addr == OFS_IEN)   ? (dlab ? baud_divisor_high : {4'h0, interrupt_enable}) :
	                    (i_addr == OFS_ISRC)  ? interrupt_source :
	                    (i_addr == OFS_FRAME) ? frame_format_control :
	                    (i_addr == OFS_PINS)  ? {3'h0, handshake_pin_control} :
	                    (i_addr == OFS_LINE)  ? serial_line_flags :
	                    (i_addr == OFS_MODEM) ? {i_modem_lines, mdelta} : scratch_byte;

	// ******************************************************
	// Software registers
	// ******************************************************
	// Host-written configuration
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			interrupt_enable      <= IEN_RST;
			frame_format_control      <= FRAME_RST;
			dll      <= BYTE_RST;
			baud_divisor_high      <= BYTE_RST;
			handshake_pin_control      <= PINS_RST;
			scratch_byte      <= BYTE_RST;
			fifo_en  <= 1'b0;
			dma_mode <= 1'b0;
			trig_sel <= TRIG_RST;
		end
		else
		begin
			if (wr_ier)
				interrupt_enable <= i_wdata[3:0];
			if (wr_lcr)
				frame_format_control <= i_wdata;
			if (wr_dll)
				dll <= i_wdata;
			if (wr_dlm)
				baud_divisor_high <= i_wdata;
			if (wr_mcr)
				handshake_pin_control <= i_wdata[4:0];
			if (wr_spr)
				scratch_byte <= i_wdata;
			if (wr_fcr)
				fifo_en <= i_wdata[QC_FIFO_EN];
			// Other fields take effect only with the enable bit set
			if (wr_fcr & i_wdata[QC_FIFO_EN])
			begin
				dma_mode <= i_wdata[QC_DMA];
				trig_sel <= i_wdata[QC_TRIG_LO+1:QC_TRIG_LO];
			end
		end
	end

	// ******************************************************
	// Status flags
	// ******************************************************
	// Sticky flags; a new event in a clearing cycle survives
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			overrun    <= 1'b0;
			head_ack   <= 1'b0;
			tx_pend    <= 1'b0;
			tx_empty_q <= 1'b1;                   // No spurious edge at reset
			mdelta     <= 4'h0;
		end
		else
		begin
			overrun    <= rx_lost | (overrun & ~rd_lsr);
			// New head byte shows its own tags again
			head_ack   <= ~(rx_pop | rx_flush) & (head_ack | rd_lsr);
			tx_pend    <= tx_set | (tx_pend & ~tx_clr);
			tx_empty_q <= tx_empty;
			mdelta     <= i_modem_delta | (mdelta & ~{4{rd_msr}});
		end
	end

	// Count of errored entries so the global flag needs no queue scan
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			err_cnt <= '0;
		else if (rx_flush)
			err_cnt <= '0;
		else
			err_cnt <= err_cnt + CW'(rx_push & (|rx_tags)) - CW'(rx_pop & head_bad);
	end

	// ******************************************************
	// Outputs
	// ******************************************************
	// Read data is held until the next read
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_rdata <= 8'h00;
		else if (rd)
			o_rdata <= rd_mux;
	end

	// Interrupt line and mirrored configuration
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_irq          <= 1'b0;
			o_divisor      <= 16'h0000;
			o_frame_format <= FRAME_RST;
			o_pin_control  <= PINS_RST;
			o_fifo_en      <= 1'b0;
			o_dma_mode     <= 1'b0;
		end
		else
		begin
			o_irq          <= (isr_code != SRC_NONE);
			o_divisor      <= {baud_divisor_high, dll};
			o_frame_format <= frame_format_control;
			o_pin_control  <= handshake_pin_control;
			o_fifo_en      <= fifo_en;
			o_dma_mode     <= dma_mode;
		end
	end

	// Hand-off stage toward the transmit shifter
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			o_tx_data  <= 8'h00;
			o_tx_valid <= 1'b0;
		end
		else if (tx_load)
		begin
			o_tx_data  <= tx_head;
			o_tx_valid <= 1'b1;
		end
		else if (i_tx_take)
			o_tx_valid <= 1'b0;
	end
endmodule : urm_channel

// >>> hdl/urm_pkg.sv
// ******************************************************
// Register map, field positions and reset values
// ******************************************************
package urm_pkg;
	// Register offsets on the three address lines
	localparam logic [2:0] OFS_DATA   = 3'h0;   // Holding registers or divisor low
	localparam logic [2:0] OFS_IEN    = 3'h1;   // Interrupt enable or divisor high
	localparam logic [2:0] OFS_ISRC   = 3'h2;   // Interrupt source read, queue control write
	localparam logic [2:0] OFS_FRAME  = 3'h3;   // Frame format control
	localparam logic [2:0] OFS_PINS   = 3'h4;   // Handshake pin control
	localparam logic [2:0] OFS_LINE   = 3'h5;   // Serial line flags
	localparam logic [2:0] OFS_MODEM  = 3'h6;   // Handshake pin flags
	localparam logic [2:0] OFS_SCR    = 3'h7;   // Scratch byte

	// Field positions
	localparam int FRM_DIV_ACCESS = 7;           // Divisor access bit of frame format
	localparam int QC_FIFO_EN     = 0;           // Queue control: FIFO enable
	localparam int QC_RX_FLUSH    = 1;           // Queue control: receive flush
	localparam int QC_TX_FLUSH    = 2;           // Queue control: transmit flush
	localparam int QC_DMA         = 3;           // Queue control: DMA mode
	localparam int QC_TRIG_LO     = 6;           // Queue control: trigger select low bit
	localparam int IEN_TXR        = 1;           // Enable bit of transmit ready source

	// Reset values
	localparam logic [3:0] IEN_RST   = 4'h0;     // All sources disabled
	localparam logic [7:0] FRAME_RST = 8'h00;    // Frame format after reset
	localparam logic [4:0] PINS_RST  = 5'h00;    // Pin control after reset
	localparam logic [7:0] BYTE_RST  = 8'h00;    // Divisor and scratch after reset
	localparam logic [1:0] TRIG_RST  = 2'h0;     // Trigger level of 1

	// Receive trigger levels, by select code
	localparam logic [4:0] TRIG_L0 = 5'h01;
	localparam logic [4:0] TRIG_L1 = 5'h04;
	localparam logic [4:0] TRIG_L2 = 5'h08;
	localparam logic [4:0] TRIG_L3 = 5'h0E;

	// Interrupt source codes, highest priority first
	localparam logic [3:0] SRC_LINE  = 4'h6;
	localparam logic [3:0] SRC_RXD   = 4'h4;
	localparam logic [3:0] SRC_TXR   = 4'h2;
	localparam logic [3:0] SRC_MODEM = 4'h0;
	localparam logic [3:0] SRC_NONE  = 4'h1;

	localparam int FIFO_DEPTH = 16;              // Character slots in each queue
	localparam int RX_WIDTH   = 11;              // Data byte plus three error tags
endpackage : urm_pkg

// >>> hdl/urm_fifo.sv
`timescale 1ns/100ps
// ******************************************************
// Character queue with level count
// ******************************************************
module urm_fifo import urm_pkg::*; #(
	parameter int WIDTH = 8,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic                       i_mclk,    // Device clock
	input  wire logic                       i_sys_rst, // Async reset, high
	input  wire logic                       i_flush,   // Drop all entries
	input  wire logic                       i_push,    // Store i_din
	input  wire logic [WIDTH-1:0]           i_din,     // Entry to store
	input  wire logic                       i_pop,     // Drop head entry
	output logic      [WIDTH-1:0]           o_head,    // Oldest entry
	output logic      [$clog2(DEPTH):0]     o_count,   // Entries held
	output logic                            o_empty,   // No entries
	output logic                            o_full     // No free slot
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];                 // Storage, no reset needed
	logic [AW-1:0]    wr_ptr;                      // Next slot to fill
	logic [AW-1:0]    rd_ptr;                      // Head slot
	logic [AW:0]      count;                       // Level

	wire do_push = i_push & ~o_full;               // Push into a full queue is lost
	wire do_pop  = i_pop & ~o_empty;               // Pop of an empty queue is ignored

	assign o_head  = mem[rd_ptr];
	assign o_count = count;
	assign o_empty = (count == '0);
	assign o_full  = (count == (AW+1)'(DEPTH));

	// Pointers and level; depth must be a power of two so pointers wrap
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else if (i_flush)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			wr_ptr <= wr_ptr + AW'(do_push);
			rd_ptr <= rd_ptr + AW'(do_pop);
			count  <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	// Storage write
	always_ff @(posedge i_mclk)
	begin
		if (do_push)
			mem[wr_ptr] <= i_din;
	end
endmodule : urm_fifo

// >>> hdl/urm_irq_prio.sv
`timescale 1ns/100ps
// ******************************************************
// Interrupt source priority encoder
// ******************************************************
module urm_irq_prio import urm_pkg::*; (
	input  wire logic       i_line,  // Enabled line status pending
	input  wire logic       i_rxd,   // Enabled receive data pending
	input  wire logic       i_txr,   // Enabled transmit ready pending
	input  wire logic       i_modem, // Enabled modem status pending
	output logic      [3:0] o_code   // Source code, none when idle
);
	// Highest pending level wins; others wait their turn
	assign o_code = i_line  ? SRC_LINE  :
	                i_rxd   ? SRC_RXD   :
	                i_txr   ? SRC_TXR   :
	                i_modem ? SRC_MODEM : SRC_NONE;
endmodule : urm_irq_prio

// >>> verification/urm_chan_assertions.sv
`timescale 1ns/100ps
// ****
// Register bus checks
// ****
module urm_chan_check (
	input wire logic        i_mclk,         // Clock
	input wire logic        i_sys_rst,      // Reset
	input wire logic        i_cs,           // Select
	input wire logic        i_rd,           // Read
	input wire logic        i_wr,           // Write
	input wire logic [2:0]  i_addr,         // Offset
	input wire logic [7:0]  i_wdata,        // Write data
	input wire logic        i_tx_busy,      // Shifter busy
	input wire logic [7:0]  o_rdata,        // Read data
	input wire logic        o_irq,          // Interrupt
	input wire logic [15:0] o_divisor,      // Divisor
	input wire logic [7:0]  o_frame_format, // Frame format
	input wire logic        o_fifo_en,      // Queues on
	input wire logic        o_dma_mode,     // DMA mode
	input wire logic        o_tx_valid      // Stage loaded
);
	wire rd_ev = i_cs && i_rd;       // Read taken
	wire wr_ev = i_cs && i_wr;       // Write taken
	wire fcr_on = wr_ev && i_addr == 3'h2 && i_wdata[0]; // Queue control write with enable
	logic dlab;                      // Divisor overlay, shadowed from frame writes
	// Shadow tracks the write itself; the mirrored port lags one cycle
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			dlab <= 1'b0;
		else if (wr_ev && i_addr == 3'h3)
			dlab <= i_wdata[7];
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	// Divisor port is one register behind the latch, so two cycles after the write
	div_low_a: assert property (wr_ev && i_addr == 3'h0 && dlab |=> ##1 o_divisor[7:0] == $past(i_wdata, 2))
		else $error("divisor low byte not loaded");
	div_high_a: assert property (wr_ev && i_addr == 3'h1 && dlab |=> ##1 o_divisor[15:8] == $past(i_wdata, 2))
		else $error("divisor high byte not loaded");
	div_guard_a: assert property (wr_ev && i_addr <= 3'h1 && !dlab |=> ##1 $stable(o_divisor))
		else $error("divisor changed without overlay");
	frame_mirror_a: assert property (wr_ev && i_addr == 3'h3 |=> ##1 o_frame_format == $past(i_wdata, 2))
		else $error("frame format not mirrored");
	// Stage counts as shifter, so a loaded stage forbids fully empty
	lsr_empty_a: assert property (rd_ev && i_addr == 3'h5 && (i_tx_busy || o_tx_valid) |=> !o_rdata[6])
		else $error("fully empty while transmitter holds data");
	isr_fixed_a: assert property (rd_ev && i_addr == 3'h2 |=> o_rdata[7:4] == {{2{o_fifo_en}}, 2'h0})
		else $error("status fixed bits wrong");
	ien_upper_a: assert property (rd_ev && i_addr == 3'h1 && !dlab |=> o_rdata[7:4] == 4'h0)
		else $error("enable upper bits not zero");
	reset_clear_a: assert property ($fell(i_sys_rst) |-> !o_irq && o_divisor == 16'h0 && !o_fifo_en)
		else $error("state not cleared by reset");
	fcr_enable_a: assert property (fcr_on |=> ##1 o_fifo_en && o_dma_mode == $past(i_wdata[3], 2))
		else $error("queue control not taken");
	cover property (rd_ev && i_addr == 3'h2 ##1 !o_rdata[0]);
	cover property (wr_ev && i_addr == 3'h1 && dlab);
	cover property ($rose(o_irq));
endmodule : urm_chan_check
bind urm_channel urm_chan_check u_chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_cs(i_cs), .i_rd(i_rd),
	.i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata), .i_tx_busy(i_tx_busy), .o_rdata(o_rdata), .o_irq(o_irq),
	.o_divisor(o_divisor), .o_frame_format(o_frame_format), .o_fifo_en(o_fifo_en), .o_dma_mode(o_dma_mode),
	.o_tx_valid(o_tx_valid));

// >>> verification/urm_shift_model.sv
`timescale 1ns/100ps
// ****
// Transmit shifter stand-in
// ****
module urm_shift_model (
	input  wire logic i_mclk,     // Clock
	input  wire logic i_sys_rst,  // Reset
	input  wire logic i_tx_valid, // Stage loaded
	input  wire logic i_stall,    // Hold off taking
	output logic      o_tx_take,  // Take pulse
	output logic      o_tx_busy   // Shifting
);
	logic [2:0] bits_left; // Shift cycles left
	// Takes only when idle, so no byte is dropped
	assign o_tx_take = i_tx_valid && !i_stall && bits_left == 3'h0;
	assign o_tx_busy = bits_left != 3'h0;
	// Short shift time keeps the run brief
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			bits_left <= 3'h0;
		else if (o_tx_take)
			bits_left <= 3'h4;
		else if (o_tx_busy)
			bits_left <= bits_left - 3'h1;
	end
endmodule : urm_shift_model

// >>> verification/urm_channel_tb.sv
`timescale 1ns/100ps
module urm_channel_tb import urm_pkg::*; ;
	logic mclk = 0, rst, cs, rd, wr, rxv, pe, fe, brk, take, busy, irq, fen, dma, txv, stall;
	logic [2:0] addr;
	logic [7:0] wdata, rxd, rdata, frame, txd;
	logic [3:0] mdelta, mlines;
	logic [15:0] divisor;
	logic [4:0] pins;
	int err_total = 0, n_compared = 0, cycles = 0;
	logic [4:0] lv [4] = '{TRIG_L0, TRIG_L1, TRIG_L2, TRIG_L3}; // Trigger per select code
	always #12.5 mclk = ~mclk;
	urm_channel i_dut (.i_mclk(mclk), .i_sys_rst(rst), .i_cs(cs), .i_rd(rd), .i_wr(wr), .i_addr(addr),
		.i_wdata(wdata), .i_rx_valid(rxv), .i_rx_data(rxd), .i_rx_parity_err(pe), .i_rx_frame_err(fe),
		.i_rx_break(brk), .i_tx_take(take), .i_tx_busy(busy), .i_modem_delta(mdelta), .i_modem_lines(mlines),
		.o_rdata(rdata), .o_irq(irq), .o_divisor(divisor), .o_frame_format(frame), .o_pin_control(pins),
		.o_fifo_en(fen), .o_dma_mode(dma), .o_tx_data(txd), .o_tx_valid(txv));
	urm_shift_model i_shift (.i_mclk(mclk), .i_sys_rst(rst), .i_tx_valid(txv), .i_stall(stall),
		.o_tx_take(take), .o_tx_busy(busy));
	// ****
	// Bus tasks, all driven at the falling edge
	// ****
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wreg(input logic [2:0] a, input logic [7:0] d);
		@(negedge mclk) {cs, wr, addr, wdata} = {2'b11, a, d};
		@(negedge mclk) {cs, wr} = 2'b00;
	endtask : wreg
	// Data stands from the edge after the strobe
	task automatic rreg(input logic [2:0] a, input logic [7:0] e);
		@(negedge mclk) {cs, rd, addr} = {2'b11, a};
		@(negedge mclk) {cs, rd} = 2'b00;
		chk(rdata, e);
	endtask : rreg
	task automatic push(input logic [7:0] d, input logic [2:0] e);
		@(negedge mclk) {rxv, rxd, brk, fe, pe} = {1'b1, d, e};
		@(negedge mclk) rxv = 0;
	endtask : push
	task automatic complete_run;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run
	// Hang guard, far above the expected run length
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			complete_run();
		end
	end
	initial
	begin
		{cs, rd, wr, addr, wdata, rxv, rxd, pe, fe, brk, mdelta, stall} = '0;
		mlines = 4'h5;
		rst = 1;
		repeat (10) @(posedge mclk);
		@(negedge mclk) rst = 0;
		rreg(OFS_ISRC, 8'h01);
		rreg(OFS_LINE, 8'h60);
		rreg(OFS_IEN, 8'h00);
		push(8'h77, 3'h0);
		push(8'h78, 3'h0);
		wreg(OFS_IEN, 8'h01);
		rreg(OFS_ISRC, 8'h04);
		rreg(OFS_LINE, 8'h63);
		rreg(OFS_DATA, 8'h77);
		$display("reset values done");
		wreg(OFS_IEN, 8'hF2);
		rreg(OFS_IEN, 8'h02);
		chk(irq, 1'b1);
		rreg(OFS_ISRC, 8'h02);
		rreg(OFS_ISRC, 8'h01);
		chk(irq, 1'b0);
		wreg(OFS_FRAME, 8'h80);
		wreg(OFS_DATA, 8'h34);
		chk(frame, 8'h80);
		wreg(OFS_IEN, 8'h12);
		rreg(OFS_DATA, 8'h34);
		rreg(OFS_IEN, 8'h12);
		chk(divisor, 16'h1234);
		wreg(OFS_FRAME, 8'h03);
		rreg(OFS_IEN, 8'h02);
		wreg(OFS_PINS, 8'hFB);
		wreg(OFS_SCR, 8'hA5);
		rreg(OFS_PINS, 8'h1B);
		rreg(OFS_SCR, 8'hA5);
		chk(pins, 5'h1B);
		$display("enable and divisor done");
		wreg(OFS_IEN, 8'h01);
		for (int k = 0; k < 4; k++)
		begin
			wreg(OFS_ISRC, {k[1:0], 6'h07});
			for (int j = 1; j < lv[k]; j++)
				push(8'hA0 + j[7:0], 3'h0);
			rreg(OFS_ISRC, 8'hC1);
			push(8'h5A, 3'h0);
			rreg(OFS_ISRC, 8'hC4);
			rreg(OFS_DATA, (k == 0) ? 8'h5A : 8'hA1);
			rreg(OFS_ISRC, 8'hC1);
		end
		$display("trigger levels done");
		wreg(OFS_IEN, 8'h04);
		wreg(OFS_ISRC, 8'h0F);
		push(8'h11, 3'h0);
		chk({fen, dma}, 2'h3);
		push(8'h22, 3'h1);
		rreg(OFS_ISRC, 8'hC1);
		rreg(OFS_LINE, 8'hE1);
		rreg(OFS_DATA, 8'h11);
		rreg(OFS_ISRC, 8'hC6);
		rreg(OFS_LINE, 8'hE5);
		rreg(OFS_ISRC, 8'hC1);
		rreg(OFS_DATA, 8'h22);
		rreg(OFS_LINE, 8'h60);
		for (int j = 0; j < 17; j++)
			push(j[7:0], 3'h0);
		rreg(OFS_ISRC, 8'hC6);
		rreg(OFS_LINE, 8'h63);
		rreg(OFS_ISRC, 8'hC1);
		$display("receive errors done");
		stall = 1;
		wreg(OFS_IEN, 8'h02);
		rreg(OFS_ISRC, 8'hC2);
		for (int j = 1; j < 4; j++)
			wreg(OFS_DATA, j[7:0]);
		rreg(OFS_LINE, 8'h01);
		chk({txv, txd}, 9'h101);
		@(negedge mclk) stall = 0;
		for (int i = 0; i < 60 && (txv || busy); i++)
			@(negedge mclk);
		rreg(OFS_ISRC, 8'hC2);
		rreg(OFS_LINE, 8'h61);
		wreg(OFS_IEN, 8'h00);
		@(negedge mclk) mdelta = 4'h2;
		@(negedge mclk) mdelta = 4'h0;
		rreg(OFS_ISRC, 8'hC1);
		wreg(OFS_IEN, 8'h08);
		rreg(OFS_ISRC, 8'hC0);
		rreg(OFS_MODEM, 8'h52);
		rreg(OFS_ISRC, 8'hC1);
		$display("transmit and modem done");
		complete_run();
	end
endmodule : urm_channel_tb
